/* File: hdl/gpt_pkg.sv */
// Shared constants and types for the general-purpose timer block
package gpt_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_MODE = 12'h004;
	localparam logic [11:0] OFS_CONTROL = 12'h00c;
	localparam logic [11:0] OFS_INT_MASK = 12'h018;
	localparam logic [11:0] OFS_RAW_STATUS = 12'h01c;
	localparam logic [11:0] OFS_MASKED_STATUS = 12'h020;
	localparam logic [11:0] OFS_INT_CLEAR = 12'h024;
	localparam logic [11:0] OFS_INTERVAL_LOAD = 12'h028;
	localparam logic [11:0] OFS_MATCH_VALUE = 12'h030;
	localparam logic [11:0] OFS_PRESCALE = 12'h038;
	localparam logic [11:0] OFS_TIMER_VALUE = 12'h048;

	// Mode register fields
	localparam int MODE_MR_LSB = 0;
	localparam int MODE_CMR_BIT = 2;
	localparam int MODE_AMS_BIT = 3;

	// Control register fields
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_EVENT_LSB = 2;
	localparam int CTL_CLK_STALL_OVR_BIT = 4;
	localparam int CTL_PWML_BIT = 6;

	// Status, mask and clear bit positions
	localparam int ST_TIMEOUT = 0;
	localparam int ST_EDGE_MATCH = 1;
	localparam int ST_CAPTURE = 2;
	localparam int ST_CLOCK_MATCH = 3;
	localparam int ST_W = 4;

	// Global configuration codes
	localparam logic [2:0] CFG_32_TIMER = 3'h0;
	localparam logic [2:0] CFG_32_CLOCK = 3'h1;
	localparam logic [2:0] CFG_16_SPLIT = 3'h4;

	// Timer-mode field codes
	localparam logic [1:0] MR_ONE_SHOT = 2'h1;
	localparam logic [1:0] MR_PERIODIC = 2'h2;
	localparam logic [1:0] MR_CAPTURE = 2'h3;

	// Event select codes
	localparam logic [1:0] EVT_RISE = 2'h0;
	localparam logic [1:0] EVT_FALL = 2'h1;

	// Reset values and the clock-mode start count
	localparam logic [31:0] RST_INTERVAL_LOAD = 32'hffffffff;
	localparam logic [31:0] RST_MATCH_VALUE = 32'hffffffff;
	localparam logic [31:0] RST_ZERO = 32'h00000000;
	localparam logic [31:0] CLOCK_START = 32'h00000001;

	// Last divider count: 32768 input rising edges per one-second tick of the clock-count mode
	localparam logic [14:0] CLOCK_DIV_LAST = 15'h7fff;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} gpt_bus_req_type;

	typedef enum logic [6:0] {
		OPM_IDLE = 7'b0000001,
		OPM_ONE_SHOT = 7'b0000010,
		OPM_PERIODIC = 7'b0000100,
		OPM_CLOCK = 7'b0001000,
		OPM_EDGE_COUNT = 7'b0010000,
		OPM_EDGE_TIME = 7'b0100000,
		OPM_PWM = 7'b1000000
	} gpt_opmode_type;

endpackage

/* File: hdl/gpt_edge_det.sv */
// Capture pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module gpt_edge_det
	import gpt_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	input wire logic [1:0] event_sel_i,
	output logic event_o,
	output logic rise_o
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} gpt_edge_state_type;

	gpt_edge_state_type s_q;
	gpt_edge_state_type s_d;
	logic rise;
	logic fall;

	// Only the second and third stages are compared
	always_comb begin
		s_d = s_q;
		s_d.meta = pin_i;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rise = s_q.sync & ~s_q.prev;
	assign fall = ~s_q.sync & s_q.prev;
	assign rise_o = rise;

	always_comb begin
		case (event_sel_i)
			EVT_RISE: event_o = rise;
			EVT_FALL: event_o = fall;
			default: event_o = rise | fall;
		endcase
	end

endmodule

/* File: hdl/gpt_timer.sv */
// General-purpose timer: one-shot, periodic, clock, capture and PWM
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module gpt_timer
	import gpt_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire gpt_bus_req_type bus_i,
	output logic [31:0] rdata_o,
	input wire logic ccp_i,
	output logic ccp_o,
	output logic ccp_oe_o
);

	typedef struct packed {
		logic [2:0] cfg;
		logic alt_mode;
		logic cap_mode;
		logic [1:0] mode;
		logic enable;
		logic [1:0] event_sel;
		logic stall_ovr;
		logic pwm_level;
		logic [ST_W-1:0] int_mask;
		logic [ST_W-1:0] raw;
		logic [31:0] load;
		logic [31:0] match;
		logic [7:0] prescale;
		logic [7:0] pre_cnt;
		logic [31:0] cnt;
		logic [15:0] captured;
		logic [14:0] clk_div;
		logic pwm_raw;
		logic pin_out;
		logic pin_oe;
		logic [31:0] rdata;
	} gpt_state_type;

	gpt_state_type s_q;
	gpt_state_type s_d;
	gpt_opmode_type opm;
	logic edge_evt;
	logic pin_rise;
	logic split;
	logic tick;
	logic [31:0] load_val;
	logic [31:0] match_val;
	logic [31:0] cnt_dec;
	logic [31:0] cnt_inc;
	logic [31:0] value_rd;
	logic [ST_W-1:0] set_st;
	logic [ST_W-1:0] clr_st;
	logic wr_cfg;
	logic wr_mode;
	logic wr_ctl;
	logic wr_imr;
	logic wr_icr;
	logic wr_load;
	logic wr_match;
	logic wr_pre;
	logic [15:0] edge_next;

	gpt_edge_det u_edge (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(ccp_i),
		.event_sel_i(s_q.event_sel),
		.event_o(edge_evt),
		.rise_o(pin_rise)
	);

	// Operating mode decode from configuration and mode fields
	always_comb begin
		opm = OPM_IDLE;
		case (s_q.cfg)
			CFG_32_TIMER: begin
				if (s_q.mode == MR_ONE_SHOT) begin
					opm = OPM_ONE_SHOT;
				end else if (s_q.mode == MR_PERIODIC) begin
					opm = OPM_PERIODIC;
				end
			end
			CFG_32_CLOCK: begin
				opm = OPM_CLOCK;
			end
			default: begin
				if (s_q.cfg[2]) begin
					if (s_q.alt_mode && !s_q.cap_mode &&
						s_q.mode == MR_PERIODIC) begin
						opm = OPM_PWM;
					end else if (s_q.mode == MR_CAPTURE) begin
						if (s_q.cap_mode) begin
							opm = OPM_EDGE_TIME;
						end else begin
							opm = OPM_EDGE_COUNT;
						end
					end else if (s_q.mode == MR_ONE_SHOT) begin
						opm = OPM_ONE_SHOT;
					end else if (s_q.mode == MR_PERIODIC) begin
						opm = OPM_PERIODIC;
					end
				end
			end
		endcase
	end

	assign split = s_q.cfg[2];
	assign load_val = split ? {16'h0000, s_q.load[15:0]} : s_q.load;
	assign match_val = split ? {16'h0000, s_q.match[15:0]} : s_q.match;
	assign cnt_dec = s_q.cnt - 32'h00000001;
	assign cnt_inc = s_q.cnt + 32'h00000001;
	assign edge_next = s_q.cnt[15:0] - 16'h0001;

	// Prescaler only in split one-shot and periodic modes
	always_comb begin
		tick = 1'b1;
		if (split && (opm == OPM_ONE_SHOT || opm == OPM_PERIODIC)) begin
			tick = (s_q.pre_cnt == 8'h00);
		end
	end

	// Register decode
	always_comb begin
		wr_cfg = bus_i.wr && bus_i.addr == OFS_CONFIG;
		wr_mode = bus_i.wr && bus_i.addr == OFS_MODE;
		wr_ctl = bus_i.wr && bus_i.addr == OFS_CONTROL;
		wr_imr = bus_i.wr && bus_i.addr == OFS_INT_MASK;
		wr_icr = bus_i.wr && bus_i.addr == OFS_INT_CLEAR;
		wr_load = bus_i.wr && bus_i.addr == OFS_INTERVAL_LOAD;
		wr_match = bus_i.wr && bus_i.addr == OFS_MATCH_VALUE;
		wr_pre = bus_i.wr && bus_i.addr == OFS_PRESCALE;
	end

	// Captured count is shown while in edge-time mode
	always_comb begin
		if (opm == OPM_EDGE_TIME) begin
			value_rd = {16'h0000, s_q.captured};
		end else if (split) begin
			value_rd = {16'h0000, s_q.cnt[15:0]};
		end else begin
			value_rd = s_q.cnt;
		end
	end

	always_comb begin
		s_d = s_q;
		set_st = '0;
		clr_st = wr_icr ? bus_i.wdata[ST_W-1:0] : '0;

		// Counting engine
		if (s_q.enable) begin
			case (opm)
				OPM_ONE_SHOT, OPM_PERIODIC: begin
					if (split) begin
						if (tick) begin
							s_d.pre_cnt = s_q.prescale;
						end else begin
							s_d.pre_cnt = s_q.pre_cnt - 8'h01;
						end
					end
					if (tick) begin
						if (s_q.cnt == 32'h00000000) begin
							s_d.cnt = load_val;
							set_st[ST_TIMEOUT] = 1'b1;
							if (opm == OPM_ONE_SHOT) begin
								s_d.enable = 1'b0;
							end
						end else begin
							s_d.cnt = cnt_dec;
						end
					end
				end
				OPM_CLOCK: begin
					if (pin_rise) begin
						s_d.clk_div = s_q.clk_div + 15'h0001;
						if (s_q.clk_div == CLOCK_DIV_LAST) begin
							if (s_q.cnt == s_q.match) begin
								s_d.cnt = RST_ZERO;
								set_st[ST_CLOCK_MATCH] = 1'b1;
							end else begin
								s_d.cnt = cnt_inc;
							end
						end
					end
				end
				OPM_EDGE_COUNT: begin
					if (edge_evt) begin
						if (edge_next == match_val[15:0]) begin
							s_d.cnt = load_val;
							s_d.enable = 1'b0;
							set_st[ST_EDGE_MATCH] = 1'b1;
						end else begin
							s_d.cnt = {16'h0000, edge_next};
						end
					end
				end
				OPM_EDGE_TIME: begin
					if (s_q.cnt[15:0] == 16'h0000) begin
						s_d.cnt = load_val;
					end else begin
						s_d.cnt = cnt_dec;
					end
					if (edge_evt) begin
						s_d.captured = s_q.cnt[15:0];
						set_st[ST_CAPTURE] = 1'b1;
					end
				end
				OPM_PWM: begin
					if (s_q.cnt[15:0] == 16'h0000) begin
						s_d.cnt = load_val;
					end else begin
						s_d.cnt = cnt_dec;
					end
					// Level from registered count only, so no glitches
					// Low half only: upper bits may be stale after reset
					if (s_q.cnt[15:0] == load_val[15:0]) begin
						s_d.pwm_raw = 1'b1;
					end else if (s_q.cnt[15:0] == match_val[15:0]) begin
						s_d.pwm_raw = 1'b0;
					end
				end
				default: begin
					s_d.cnt = s_q.cnt;
				end
			endcase
		end

		if (opm == OPM_PWM) begin
			set_st = '0;
		end

		// Set wins over a clear in the same cycle
		s_d.raw = (s_q.raw & ~clr_st) | set_st;

		s_d.pin_out = s_d.pwm_raw ^ s_d.pwm_level;
		s_d.pin_oe = (opm == OPM_PWM);

		// Software writes; setup assumed made with timer disabled
		if (wr_cfg) begin
			s_d.cfg = bus_i.wdata[2:0];
			if (bus_i.wdata[2:0] == CFG_32_CLOCK) begin
				s_d.cnt = CLOCK_START;
				s_d.clk_div = '0;
			end
		end
		if (wr_mode) begin
			s_d.mode = bus_i.wdata[MODE_MR_LSB +: 2];
			s_d.cap_mode = bus_i.wdata[MODE_CMR_BIT];
			s_d.alt_mode = bus_i.wdata[MODE_AMS_BIT];
		end
		if (wr_ctl) begin
			s_d.enable = bus_i.wdata[CTL_EN_BIT];
			s_d.event_sel = bus_i.wdata[CTL_EVENT_LSB +: 2];
			// Stored only: there is no halt input to stall on
			s_d.stall_ovr = bus_i.wdata[CTL_CLK_STALL_OVR_BIT];
			s_d.pwm_level = bus_i.wdata[CTL_PWML_BIT];
			s_d.pin_out = s_d.pwm_raw ^ bus_i.wdata[CTL_PWML_BIT];
			if (bus_i.wdata[CTL_EN_BIT] && !s_q.enable) begin
				s_d.pre_cnt = s_q.prescale;
			end
		end
		if (wr_imr) begin
			s_d.int_mask = bus_i.wdata[ST_W-1:0];
		end
		if (wr_load) begin
			s_d.load = bus_i.wdata;
			if (opm != OPM_CLOCK) begin
				// New start value seen on the next cycle
				s_d.cnt = split ? {16'h0000, bus_i.wdata[15:0]}
					: bus_i.wdata;
				s_d.pre_cnt = s_q.prescale;
			end
		end
		if (wr_match) begin
			s_d.match = bus_i.wdata;
		end
		if (wr_pre) begin
			s_d.prescale = bus_i.wdata[7:0];
		end

		// Read data valid only in the cycle after the strobe
		s_d.rdata = '0;
		if (bus_i.rd) begin
			case (bus_i.addr)
				OFS_CONFIG: s_d.rdata = {29'h0, s_q.cfg};
				OFS_MODE: s_d.rdata = {28'h0, s_q.alt_mode,
					s_q.cap_mode, s_q.mode};
				OFS_CONTROL: s_d.rdata = {25'h0, s_q.pwm_level, 1'b0,
					s_q.stall_ovr, s_q.event_sel, 1'b0, s_q.enable};
				OFS_INT_MASK: s_d.rdata = {28'h0, s_q.int_mask};
				OFS_RAW_STATUS: s_d.rdata = {28'h0, s_q.raw};
				OFS_MASKED_STATUS: s_d.rdata = {28'h0,
					s_q.raw & s_q.int_mask};
				OFS_INTERVAL_LOAD: s_d.rdata = s_q.load;
				OFS_MATCH_VALUE: s_d.rdata = s_q.match;
				OFS_PRESCALE: s_d.rdata = {24'h0, s_q.prescale};
				OFS_TIMER_VALUE: s_d.rdata = value_rd;
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.load <= RST_INTERVAL_LOAD;
			s_q.match <= RST_MATCH_VALUE;
			s_q.cnt <= RST_INTERVAL_LOAD;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign ccp_o = s_q.pin_out;
	assign ccp_oe_o = s_q.pin_oe;

endmodule

/* File: sim/gpt_timer_properties.sv */
// Port-level properties of the general-purpose timer
`timescale 1ns/1ps
module gpt_timer_properties
	import gpt_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire gpt_bus_req_type bus_i,
	input wire logic [31:0] rdata_o,
	input wire logic ccp_i,
	input wire logic ccp_o,
	input wire logic ccp_oe_o
);
	typedef struct packed {
		logic [2:0] cfg;
		logic [3:0] mode;
		logic [3:0] mask;
		logic [7:0] pre;
		logic [31:0] load;
		logic [31:0] match;
	} gpt_shadow_type;
	gpt_shadow_type sh_q;
	gpt_shadow_type sh_d;
	logic pwm_sel;

	// Shadow of the plain storage registers, which hardware never alters
	always_comb begin
		sh_d = sh_q;
		if (bus_i.wr) begin
			case (bus_i.addr)
			OFS_CONFIG: sh_d.cfg = bus_i.wdata[2:0];
			OFS_MODE: sh_d.mode = bus_i.wdata[3:0];
			OFS_INT_MASK: sh_d.mask = bus_i.wdata[3:0];
			OFS_PRESCALE: sh_d.pre = bus_i.wdata[7:0];
			OFS_INTERVAL_LOAD: sh_d.load = bus_i.wdata;
			OFS_MATCH_VALUE: sh_d.match = bus_i.wdata;
			default: ;
			endcase
		end
		if (sys_rst_i) begin
			sh_d = '0;
			sh_d.load = RST_INTERVAL_LOAD;
			sh_d.match = RST_MATCH_VALUE;
		end
	end
	always_ff @(posedge clock_i) begin
		sh_q <= sh_d;
	end
	assign pwm_sel = sh_q.mode == 4'ha;

	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	property rb(logic [11:0] a, logic [31:0] v);
		bus_i.rd && bus_i.addr == a |=> rdata_o == v;
	endproperty

	a_read_idle_zero: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
		else $error("read data not zero outside a read");
	a_cfg_readback: assert property (rb(OFS_CONFIG, {29'h0, sh_q.cfg}))
		else $error("config readback wrong");
	a_mode_readback: assert property (rb(OFS_MODE, {28'h0, sh_q.mode}))
		else $error("mode readback wrong");
	a_load_readback: assert property (rb(OFS_INTERVAL_LOAD, sh_q.load))
		else $error("interval load readback wrong");
	a_match_readback: assert property (rb(OFS_MATCH_VALUE, sh_q.match))
		else $error("match readback wrong");
	a_pre_readback: assert property (rb(OFS_PRESCALE, {24'h0, sh_q.pre}))
		else $error("prescale readback wrong");
	a_masked_subset: assert property (bus_i.rd
		&& bus_i.addr == OFS_MASKED_STATUS
		|=> (rdata_o[3:0] & ~sh_q.mask) == 4'h0 && rdata_o[31:4] == '0)
		else $error("masked status outside mask");
	a_oe_needs_pwm: assert property (!pwm_sel && !$past(pwm_sel)
		|-> !ccp_oe_o)
		else $error("pin driven outside pwm mode");

	c_pwm_on: cover property ($rose(ccp_oe_o));
	c_pwm_edge: cover property (ccp_oe_o && $rose(ccp_o));
	c_clear: cover property (bus_i.wr && bus_i.addr == OFS_INT_CLEAR);
endmodule

bind gpt_timer gpt_timer_properties u_props (
	.clock_i(clock_i),
	.sys_rst_i(sys_rst_i),
	.bus_i(bus_i),
	.rdata_o(rdata_o),
	.ccp_i(ccp_i),
	.ccp_o(ccp_o),
	.ccp_oe_o(ccp_oe_o)
);

/* File: sim/gpt_pin_partner.sv */
// Edge source and PWM load standing on the capture/compare pin
`timescale 1ns/1ps
module gpt_pin_partner (
	input wire logic clock_i,
	input wire logic pwm_i,
	input wire logic pwm_oe_i,
	output logic pin_o
);
	int hi_cnt = 0;
	initial pin_o = 1'b0;

	// Each level stands whole cycles, at least two, so edges stay countable
	task automatic pulse(input int hi, input int lo);
		pin_o <= 1'b1;
		repeat (hi) @(posedge clock_i);
		pin_o <= 1'b0;
		repeat (lo) @(posedge clock_i);
	endtask

	always @(posedge clock_i) begin
		if (pwm_oe_i && pwm_i) begin
			hi_cnt <= hi_cnt + 1;
		end
	end
endmodule

/* File: sim/gp_timer_capture_pwm_tb.sv */
// Self-checking bench for the general-purpose timer
`timescale 1ns/1ps
module gp_timer_capture_pwm_tb
	import gpt_pkg::*;
;
	logic clock_i;
	logic sys_rst_i;
	gpt_bus_req_type bus;
	logic [31:0] rdata_o;
	logic ccp_i;
	logic ccp_o;
	logic ccp_oe_o;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] v1;
	logic [31:0] v2;
	logic [75:0] rows [5];

	gpt_timer uut (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.bus_i(bus),
		.rdata_o(rdata_o),
		.ccp_i(ccp_i),
		.ccp_o(ccp_o),
		.ccp_oe_o(ccp_oe_o)
	);
	gpt_pin_partner pin (
		.clock_i(clock_i),
		.pwm_i(ccp_o),
		.pwm_oe_i(ccp_oe_o),
		.pin_o(ccp_i)
	);

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// The tests need under two thousand cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic rst();
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
	endtask

	// Idle cycle after each strobe so no signal is set twice at one edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock_i);
		bus.wr <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock_i);
		bus.rd <= 1'b0;
		#1 d = rdata_o;
		@(posedge clock_i);
	endtask

	task automatic chk(string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rc(string n, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(n, d & m, e);
	endtask

	// High cycles seen by the load over exactly 100 cycles
	task automatic duty(input int e);
		repeat (20) @(posedge clock_i);
		#1 pin.hi_cnt = 0;
		repeat (100) @(posedge clock_i);
		#1 chk("pwm high cycles", 32'(pin.hi_cnt), 32'(e));
	endtask

	initial begin
		sys_rst_i = 1'b1;
		bus = '0;
		rows[0] = {OFS_CONFIG, 32'h4, 32'h4};
		rows[1] = {OFS_CONFIG, 32'h1, 32'h1};
		rows[2] = {OFS_MODE, 32'h7, 32'h7};
		rows[3] = {OFS_PRESCALE, 32'h1ff, 32'hff};
		rows[4] = {12'h008, 32'h5, 32'h0};
		rst();
		foreach (rows[i]) begin
			wr(rows[i][75:64], rows[i][63:32]);
			rc("readback", rows[i][75:64], '1, rows[i][31:0]);
		end
		rst();
		rc("load reset", OFS_INTERVAL_LOAD, '1, RST_INTERVAL_LOAD);
		rc("match reset", OFS_MATCH_VALUE, '1, RST_MATCH_VALUE);
		rc("config reset", OFS_CONFIG, '1, 32'h0);
		$display("registers done");
		wr(OFS_CONFIG, 32'h4);
		wr(OFS_MODE, 32'h7);
		wr(OFS_INTERVAL_LOAD, 32'h40);
		wr(OFS_INT_MASK, 32'h4);
		wr(OFS_CONTROL, 32'h1);
		pin.pulse(4, 4);
		rd(OFS_TIMER_VALUE, v1);
		chk("capture range", 32'(v1 <= 32'h40), 32'h1);
		rc("capture raw", OFS_RAW_STATUS, 32'h4, 32'h4);
		rc("capture masked", OFS_MASKED_STATUS, 32'h4, 32'h4);
		repeat (100) @(posedge clock_i);
		rc("capture held", OFS_TIMER_VALUE, '1, v1);
		wr(OFS_INT_CLEAR, 32'h4);
		rc("capture cleared", OFS_RAW_STATUS, 32'h4, 32'h0);
		pin.pulse(4, 4);
		rd(OFS_TIMER_VALUE, v2);
		chk("recapture", 32'(v2 != v1), 32'h1);
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_INT_CLEAR, 32'h4);
		wr(OFS_CONTROL, 32'h5);
		pin.pulse(4, 0);
		rc("fall not yet", OFS_RAW_STATUS, 32'h4, 32'h0);
		repeat (2) @(posedge clock_i);
		rc("fall capture", OFS_RAW_STATUS, 32'h4, 32'h4);
		wr(OFS_CONTROL, 32'h0);
		$display("edge time done");
		wr(OFS_MODE, 32'ha);
		wr(OFS_PRESCALE, 32'hff);
		wr(OFS_INTERVAL_LOAD, 32'h9);
		wr(OFS_MATCH_VALUE, 32'h3);
		wr(OFS_INT_CLEAR, 32'hf);
		wr(OFS_CONTROL, 32'h1);
		duty(60);
		chk("pin driven", {31'h0, ccp_oe_o}, 32'h1);
		rc("pwm flags", OFS_RAW_STATUS, '1, 32'h0);
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_CONTROL, 32'h1 | (32'h1 << CTL_PWML_BIT));
		duty(40);
		wr(OFS_INTERVAL_LOAD, 32'h4);
		duty(80);
		wr(OFS_CONTROL, 32'h0);
		$display("pwm done");
		wr(OFS_MODE, 32'h3);
		wr(OFS_INTERVAL_LOAD, 32'ha);
		wr(OFS_MATCH_VALUE, 32'h6);
		wr(OFS_CONTROL, 32'h9);
		repeat (3) pin.pulse(3, 3);
		rc("count stopped", OFS_CONTROL, 32'h1, 32'h0);
		rc("count match", OFS_RAW_STATUS, 32'h2, 32'h2);
		rc("count reload", OFS_TIMER_VALUE, 32'hffff, 32'ha);
		$display("edge count done");
		wr(OFS_CONFIG, 32'h0);
		wr(OFS_MODE, 32'h1);
		wr(OFS_INTERVAL_LOAD, 32'h14);
		wr(OFS_INT_CLEAR, 32'hf);
		wr(OFS_CONTROL, 32'h1);
		repeat (40) @(posedge clock_i);
		rc("one-shot stop", OFS_CONTROL, 32'h1, 32'h0);
		rc("timeout", OFS_RAW_STATUS, 32'h1, 32'h1);
		wr(OFS_INT_CLEAR, 32'h1);
		rc("timeout clear", OFS_RAW_STATUS, 32'h1, 32'h0);
		wr(OFS_MODE, 32'h2);
		wr(OFS_CONTROL, 32'h1);
		repeat (60) @(posedge clock_i);
		rc("periodic run", OFS_CONTROL, 32'h1, 32'h1);
		rc("periodic timeout", OFS_RAW_STATUS, 32'h1, 32'h1);
		$display("timer modes done");
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_CONFIG, 32'h1);
		rc("clock start", OFS_TIMER_VALUE, '1, CLOCK_START);
		wr(OFS_CONTROL, 32'h1);
		repeat (4) pin.pulse(2, 2);
		rc("clock held", OFS_TIMER_VALUE, '1, CLOCK_START);
		rc("clock running", OFS_CONTROL, 32'h1, 32'h1);
		$display("clock mode done");
		tally_and_finish();
	end
endmodule
